// File: hw/dfi_train_pkg.sv
// package: register map, field layout and types of the dfi timing block
package dfi_train_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_ZQ = 12'h278;
  localparam logic [11:0] OFS_RDEN = 12'h300;
  localparam logic [11:0] OFS_RDLAT = 12'h304;
  localparam logic [11:0] OFS_WREN = 12'h308;
  localparam logic [11:0] OFS_RCTL = 12'h310;
  localparam logic [11:0] OFS_RMRS = 12'h314;
  localparam logic [11:0] OFS_RGAP = 12'h318;
  localparam logic [11:0] OFS_RCMD = 12'h31C;
  localparam logic [11:0] OFS_WCTL = 12'h320;
  localparam logic [11:0] OFS_CMD = 12'h330;
  localparam logic [11:0] OFS_STAT = 12'h334;
  // reset values
  localparam logic [31:0] RST_ZQ = 32'h00000040;
  localparam logic [31:0] RST_RDEN = 32'h00000001;
  localparam logic [31:0] RST_RDLAT = 32'h00000000;
  localparam logic [31:0] RST_WREN = 32'h00000001;
  localparam logic [31:0] RST_RCTL = 32'h00001080;
  localparam logic [31:0] RST_RMRS = 32'h00000004;
  localparam logic [31:0] RST_RGAP = 32'h00000000;
  localparam logic [31:0] RST_RCMD = 32'h00000000;
  localparam logic [31:0] RST_WCTL = 32'h00001000;
  // writable bits per register
  localparam logic [31:0] MSK_ZQ = 32'h000003FF;
  localparam logic [31:0] MSK_RDEN = 32'h001F3F3F;
  localparam logic [31:0] MSK_RDLAT = 32'h0000003F;
  localparam logic [31:0] MSK_WREN = 32'h011F1F1F;
  localparam logic [31:0] MSK_RCTL = 32'h010F7611;
  localparam logic [31:0] MSK_RMRS = 32'h00001FFF;
  localparam logic [31:0] MSK_RGAP = 32'h0000003F;
  localparam logic [31:0] MSK_RCMD = 32'h000003FF;
  localparam logic [31:0] MSK_WCTL = 32'h000F7000;
  // field positions
  localparam int RD_CS_LSB = 16;
  localparam int WR_DLY_BIT = 24;
  localparam int PREAMBLE_BIT = 24;
  localparam int PAT_LSB = 16;
  localparam int ERR_EN_BIT = 14;
  localparam int REF_DUR_BIT = 13;
  localparam int REF_PRE_BIT = 12;
  localparam int BANK_LSB = 9;
  localparam int SETUP_BIT = 4;
  localparam int MODE_BIT = 0;
  // command register bits
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_ZQ_BIT = 2;
  localparam int CMD_RTRAIN_BIT = 3;
  localparam int CMD_WTRAIN_BIT = 4;
  localparam int CMD_REF_BIT = 5;
  // command encoding on the dfi side
  typedef enum logic [2:0] {
    DCMD_NOP, DCMD_READ, DCMD_WRITE, DCMD_ZQ, DCMD_REF, DCMD_MRS,
    DCMD_TRAIN
  } dfi_cmd_t;
  // command bundle toward the phy
  typedef struct packed {
    logic cs_n;
    dfi_cmd_t cmd;
    logic [1:0] bank;
    logic [12:0] addr;
  } dfi_ctl_t;
  localparam logic [1:0] MR3_BANK = 2'h3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : dfi_train_pkg

// File: hw/dfi_train_ctrl.sv
// dfi timing and training controller with an axi4-lite register slave
`timescale 1ns/10ps
module dfi_train_ctrl
  import dfi_train_pkg::*;
#(
  parameter int REF_INTERVAL = 64 // cycles between refreshes in training
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic rst_i, // async reset, active high
  input wire logic [11:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [11:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  output dfi_train_pkg::dfi_ctl_t dfi_ctl_o, // command bundle
  output logic dfi_rddata_en_o, // read data enable
  output logic dfi_rddata_cs_n_o, // read data chip-select
  input wire logic dfi_rddata_valid_i, // read data valid from phy
  output logic dfi_wrdata_en_o, // write data enable
  output logic dfi_wrdata_cs_n_o, // write data chip-select
  output logic dfi_wrdata_o, // write data present strobe
  output logic dfi_rdlvl_en_o, // read leveling enable
  output logic dfi_wrlvl_en_o, // write leveling enable
  output logic [3:0] dfi_lvl_pattern_o, // leveling pattern
  input wire logic dfi_lvl_resp_i, // leveling done response
  input wire logic dfi_err_i // training error report
);
  import dfi_train_pkg::*;

  typedef enum {
    T_IDLE, T_PREREF, T_PREAMB, T_SETUP, T_EN, T_GAP, T_CMD, T_REF,
    T_WAITEND, T_EXIT
  } train_st_t;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] zq_ff, rden_ff, rdlat_ff, wren_ff, rctl_ff, rmrs_ff;
  logic [31:0] rgap_ff, rcmd_ff, wctl_ff;
  logic [11:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff, late_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] wmask;
  logic do_write, rd_hit, wr_hit, cmd_wr;
  logic [31:0] rd_word;
  logic [11:0] ra;
  logic [31:0] status;

  // strobe mask and write decode
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}},
                  {8{wstrb_ff[0]}}};
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_hit = waddr_ff inside {OFS_ZQ, OFS_RDEN, OFS_RDLAT, OFS_WREN,
    OFS_RCTL, OFS_RMRS, OFS_RGAP, OFS_RCMD, OFS_WCTL, OFS_CMD};
  assign cmd_wr = do_write && waddr_ff == OFS_CMD;

  function automatic logic [31:0] upd(input logic [31:0] old,
                                      input logic [31:0] msk);
    upd = ((old & ~wmask) | (wdata_ff & wmask)) & msk;
  endfunction : upd

  // address and data are caught in either order
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      waddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid_i && !aw_have_ff) begin
        aw_have_ff <= 1'b1;
        waddr_ff <= {s_axi_awaddr_i[11:2], 2'h0};
      end
      if (s_axi_wvalid_i && !w_have_ff) begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end
      if (bvalid_ff && s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
      end
    end
  end

  // configuration registers; alignment fields are stored only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      zq_ff <= RST_ZQ;
      rden_ff <= RST_RDEN;
      rdlat_ff <= RST_RDLAT;
      wren_ff <= RST_WREN;
      rctl_ff <= RST_RCTL;
      rmrs_ff <= RST_RMRS;
      rgap_ff <= RST_RGAP;
      rcmd_ff <= RST_RCMD;
      wctl_ff <= RST_WCTL;
    end else if (do_write) begin
      case (waddr_ff)
        OFS_ZQ: zq_ff <= upd(zq_ff, MSK_ZQ);
        OFS_RDEN: rden_ff <= upd(rden_ff, MSK_RDEN);
        OFS_RDLAT: rdlat_ff <= upd(rdlat_ff, MSK_RDLAT);
        OFS_WREN: wren_ff <= upd(wren_ff, MSK_WREN);
        OFS_RCTL: rctl_ff <= upd(rctl_ff, MSK_RCTL);
        OFS_RMRS: rmrs_ff <= upd(rmrs_ff, MSK_RMRS);
        OFS_RGAP: rgap_ff <= upd(rgap_ff, MSK_RGAP);
        OFS_RCMD: rcmd_ff <= upd(rcmd_ff, MSK_RCMD);
        OFS_WCTL: wctl_ff <= upd(wctl_ff, MSK_WCTL);
        default: ;
      endcase
    end
  end

  // read decode
  assign ra = {s_axi_araddr_i[11:2], 2'h0};
  assign rd_hit = ra inside {OFS_ZQ, OFS_RDEN, OFS_RDLAT, OFS_WREN,
    OFS_RCTL, OFS_RMRS, OFS_RGAP, OFS_RCMD, OFS_WCTL, OFS_CMD, OFS_STAT};
  assign rd_word = (ra == OFS_ZQ) ? zq_ff :
                   (ra == OFS_RDEN) ? rden_ff :
                   (ra == OFS_RDLAT) ? rdlat_ff :
                   (ra == OFS_WREN) ? wren_ff :
                   (ra == OFS_RCTL) ? rctl_ff :
                   (ra == OFS_RMRS) ? rmrs_ff :
                   (ra == OFS_RGAP) ? rgap_ff :
                   (ra == OFS_RCMD) ? rcmd_ff :
                   (ra == OFS_WCTL) ? wctl_ff :
                   (ra == OFS_STAT) ? status : 32'h00000000;

  // read channel answers one cycle after the address
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= AXI_OKAY;
    end else if (rvalid_ff) begin
      if (s_axi_rready_i) rvalid_ff <= 1'b0;
    end else if (s_axi_arvalid_i) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end
  end

  assign s_axi_awready_o = !aw_have_ff;
  assign s_axi_wready_o = !w_have_ff;
  assign s_axi_arready_o = !rvalid_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // ----------------------------------------------------------------
  // command issue and latency pipes
  // ----------------------------------------------------------------
  train_st_t st_ff;
  logic [9:0] hold_ff; // zq blocking counter
  logic [9:0] gap_ff; // training gap counter
  logic [63:0] rd_sh_ff, rdcs_sh_ff, wr_sh_ff, wrcs_sh_ff;
  logic wrd_ff;
  dfi_ctl_t ctl_ff;
  logic busy, rd_go, wr_go, zq_go, is_wr_train;
  logic [5:0] rd_lat, rd_max;
  logic [4:0] rd_cs_lat, wr_lat, wr_cs_lat;
  logic [5:0] since_en_ff;
  logic wait_ff;
  logic [31:0] train_ctl;
  logic ref_due;
  logic [15:0] ref_cnt_ff;

  assign rd_lat = rden_ff[5:0];
  assign rd_cs_lat = rden_ff[RD_CS_LSB +: 5];
  assign wr_lat = wren_ff[4:0];
  assign wr_cs_lat = wren_ff[RD_CS_LSB +: 5];
  assign rd_max = rdlat_ff[5:0];
  assign busy = hold_ff != 10'h000 || st_ff != T_IDLE;
  assign rd_go = cmd_wr && wdata_ff[CMD_READ_BIT] && !busy;
  assign wr_go = cmd_wr && wdata_ff[CMD_WRITE_BIT] && !busy && !rd_go;
  assign zq_go = cmd_wr && wdata_ff[CMD_ZQ_BIT] && !busy && !rd_go &&
                 !wr_go;
  assign train_ctl = is_wr_train ? wctl_ff : rctl_ff;
  assign ref_due = ref_cnt_ff >= 16'(REF_INTERVAL);

  // latency shift lines: bit n fires n cycles after the command
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_sh_ff <= 64'h0;
      rdcs_sh_ff <= 64'h0;
      wr_sh_ff <= 64'h0;
      wrcs_sh_ff <= 64'h0;
      wrd_ff <= 1'b0;
    end else begin
      rd_sh_ff <= (rd_sh_ff >> 1) | (64'(rd_go) << rd_lat);
      rdcs_sh_ff <= (rdcs_sh_ff >> 1) | (64'(rd_go) << rd_cs_lat);
      wr_sh_ff <= (wr_sh_ff >> 1) | (64'(wr_go) << wr_lat);
      wrcs_sh_ff <= (wrcs_sh_ff >> 1) | (64'(wr_go) << wr_cs_lat);
      wrd_ff <= wr_sh_ff[0];
    end
  end

  assign dfi_rddata_en_o = rd_sh_ff[0];
  assign dfi_rddata_cs_n_o = !rdcs_sh_ff[0];
  assign dfi_wrdata_en_o = wr_sh_ff[0];
  assign dfi_wrdata_cs_n_o = !wrcs_sh_ff[0];
  // data goes with the enable or one cycle after it
  assign dfi_wrdata_o = wren_ff[WR_DLY_BIT] ? wrd_ff : wr_sh_ff[0];

  // read return window watch: late flag if valid misses the window
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_ff <= 1'b0;
      since_en_ff <= 6'h00;
      late_ff <= 1'b0;
    end else if (dfi_rddata_en_o) begin
      wait_ff <= 1'b1;
      since_en_ff <= 6'h00;
    end else if (wait_ff) begin
      if (dfi_rddata_valid_i) wait_ff <= 1'b0;
      else if (since_en_ff >= rd_max) begin
        wait_ff <= 1'b0;
        late_ff <= 1'b1;
      end else since_en_ff <= since_en_ff + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // training sequencer and zq hold
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= T_IDLE;
      hold_ff <= 10'h000;
      gap_ff <= 10'h000;
      ctl_ff <= '{cs_n: 1'b1, cmd: DCMD_NOP, bank: 2'h0, addr: 13'h0};
      is_wr_train <= 1'b0;
      ref_cnt_ff <= 16'h0000;
    end else begin
      ctl_ff <= '{cs_n: 1'b1, cmd: DCMD_NOP, bank: 2'h0, addr: 13'h0};
      if (hold_ff != 10'h000) hold_ff <= hold_ff - 10'h001;
      if (gap_ff != 10'h000) gap_ff <= gap_ff - 10'h001;
      if (st_ff != T_IDLE && !ref_due) ref_cnt_ff <= ref_cnt_ff + 16'h1;
      if (rd_go) ctl_ff <= '{1'b0, DCMD_READ, 2'h0, 13'h0};
      if (wr_go) ctl_ff <= '{1'b0, DCMD_WRITE, 2'h0, 13'h0};
      if (zq_go) begin
        ctl_ff <= '{1'b0, DCMD_ZQ, 2'h0, 13'h0};
        hold_ff <= zq_ff[9:0];
      end
      case (st_ff)
        T_IDLE: begin
          if (cmd_wr && !busy && !rd_go && !wr_go && !zq_go &&
              (wdata_ff[CMD_RTRAIN_BIT] || wdata_ff[CMD_WTRAIN_BIT])) begin
            is_wr_train <= !wdata_ff[CMD_RTRAIN_BIT];
            ref_cnt_ff <= 16'h0000;
            st_ff <= T_PREREF;
          end
        end
        T_PREREF: begin
          if (train_ctl[REF_PRE_BIT])
            ctl_ff <= '{1'b0, DCMD_REF, 2'h0, 13'h0};
          gap_ff <= {4'h0, rgap_ff[5:0]};
          st_ff <= T_PREAMB;
        end
        T_PREAMB: if (gap_ff == 10'h000) begin
          if (!is_wr_train && rctl_ff[PREAMBLE_BIT]) begin
            ctl_ff <= '{1'b0, DCMD_MRS, MR3_BANK, rmrs_ff[12:0]};
            gap_ff <= {4'h0, rgap_ff[5:0]};
          end
          st_ff <= T_SETUP;
        end
        T_SETUP: if (gap_ff == 10'h000) begin
          if (!is_wr_train && rctl_ff[SETUP_BIT]) begin
            ctl_ff <= '{1'b0, DCMD_MRS, MR3_BANK, rmrs_ff[12:0]};
            gap_ff <= {4'h0, rgap_ff[5:0]};
          end
          st_ff <= T_EN;
        end
        T_EN: if (gap_ff == 10'h000) begin
          gap_ff <= {4'h0, rgap_ff[5:0]};
          st_ff <= T_GAP;
        end
        T_GAP: if (gap_ff == 10'h000) begin
          if (train_ctl[REF_DUR_BIT] && ref_due) begin
            ctl_ff <= '{1'b0, DCMD_REF, 2'h0, 13'h0};
            ref_cnt_ff <= 16'h0000;
            gap_ff <= {4'h0, rgap_ff[5:0]};
            st_ff <= T_REF;
          end else begin
            ctl_ff <= '{1'b0, DCMD_TRAIN,
              is_wr_train ? 2'h0 : rctl_ff[BANK_LSB +: 2],
              {12'h000, train_ctl[MODE_BIT]}};
            gap_ff <= rcmd_ff[9:0];
            st_ff <= T_CMD;
          end
        end
        T_REF: if (gap_ff == 10'h000) begin
          gap_ff <= {4'h0, rgap_ff[5:0]};
          st_ff <= T_GAP; // resume after refresh
        end
        T_CMD: begin
          if (dfi_err_i && train_ctl[ERR_EN_BIT]) st_ff <= T_GAP;
          else if (dfi_lvl_resp_i) st_ff <= T_WAITEND;
          else if (gap_ff == 10'h000) st_ff <= T_GAP;
        end
        T_WAITEND: if (gap_ff == 10'h000) begin
          gap_ff <= {4'h0, rgap_ff[5:0]};
          st_ff <= T_EXIT;
        end
        T_EXIT: if (gap_ff == 10'h000) st_ff <= T_IDLE;
        default: st_ff <= T_IDLE;
      endcase
    end
  end

  logic lvl_on;
  assign lvl_on = st_ff inside {T_GAP, T_CMD, T_REF, T_WAITEND};
  assign dfi_rdlvl_en_o = lvl_on && !is_wr_train;
  assign dfi_wrlvl_en_o = lvl_on && is_wr_train;
  assign dfi_lvl_pattern_o = lvl_on ? train_ctl[PAT_LSB +: 4] : 4'h0;
  assign dfi_ctl_o = ctl_ff;
  assign status = {28'h0, late_ff, lvl_on, st_ff != T_IDLE,
                   hold_ff != 10'h000};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_zq_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
    zq_go |=> hold_ff == $past(zq_ff[9:0]);
  endproperty
  a_zq_hold: assert property (p_zq_hold) else $error("zq hold");
  property p_zq_block;
    @(posedge ref_clk_i) disable iff (rst_i)
    hold_ff != 10'h000 |-> !rd_go && !wr_go;
  endproperty
  a_zq_block: assert property (p_zq_block) else $error("zq blk");
  property p_rd_cmd;
    @(posedge ref_clk_i) disable iff (rst_i)
    rd_go |=> dfi_ctl_o.cmd == DCMD_READ;
  endproperty
  a_rd_cmd: assert property (p_rd_cmd) else $error("rd cmd");
  property p_wr_data;
    @(posedge ref_clk_i) disable iff (rst_i)
    dfi_wrdata_en_o && !wren_ff[WR_DLY_BIT] |-> dfi_wrdata_o;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("wr data");
  property p_pat;
    @(posedge ref_clk_i) disable iff (rst_i)
    !lvl_on |-> dfi_lvl_pattern_o == 4'h0;
  endproperty
  a_pat: assert property (p_pat) else $error("pattern");
  property p_bank;
    @(posedge ref_clk_i) disable iff (rst_i)
    st_ff == T_GAP && gap_ff == 10'h000 && !is_wr_train && !ref_due
      |=> dfi_ctl_o.bank == $past(rctl_ff[10:9]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank");
  // training commands never come closer than the minimum command gap
  property p_gap;
    @(posedge ref_clk_i) disable iff (rst_i)
    !dfi_ctl_o.cs_n && dfi_ctl_o.cmd == DCMD_TRAIN
      |=> (dfi_ctl_o.cmd != DCMD_TRAIN)[*3];
  endproperty
  a_gap: assert property (p_gap) else $error("train gap");
  property p_en_gap;
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(lvl_on) |-> dfi_ctl_o.cmd != DCMD_TRAIN;
  endproperty
  a_en_gap: assert property (p_en_gap) else $error("en gap");
  // a reported error with replay enabled sends the sequencer back to gap
  property p_replay;
    @(posedge ref_clk_i) disable iff (rst_i)
    st_ff == T_CMD && dfi_err_i && train_ctl[ERR_EN_BIT] |=> st_ff == T_GAP;
  endproperty
  a_replay: assert property (p_replay) else $error("replay");
endmodule : dfi_train_ctrl

// File: tb/dfi_phy_model.sv
// phy model: answers read enables and leveling requests
`timescale 1ns/10ps
module dfi_phy_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset, active high
  input wire logic rd_en_i, // read data enable
  input wire logic lvl_en_i, // any leveling enable
  input wire logic [5:0] delay_i, // read return delay
  output logic valid_o, // read data valid
  output logic resp_o // leveling done
);
  logic [5:0] rd_cnt_ff;
  logic [4:0] lvl_cnt_ff;
  // count down the read return, count up while leveling is enabled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_cnt_ff <= 6'h00;
      lvl_cnt_ff <= 5'h00;
    end else begin
      rd_cnt_ff <= rd_en_i ? delay_i : rd_cnt_ff - 6'(rd_cnt_ff != 6'h00);
      lvl_cnt_ff <= lvl_en_i ? lvl_cnt_ff + 5'(lvl_cnt_ff != 5'h1F) : 5'h00;
    end
  end
  assign valid_o = (rd_cnt_ff == 6'h01);
  assign resp_o = (lvl_cnt_ff == 5'h1F); // held until enable drops
endmodule : dfi_phy_model

// File: tb/dfi_train_ctrl_tb_top.sv
// testbench for the dfi timing and training controller
`timescale 1ns/10ps
module dfi_train_ctrl_tb_top;
  import dfi_train_pkg::*;
  localparam logic [11:0] OFS_TAB[9] = '{OFS_ZQ, OFS_RDEN, OFS_RDLAT,
    OFS_WREN, OFS_RCTL, OFS_RMRS, OFS_RGAP, OFS_RCMD, OFS_WCTL};
  localparam logic [31:0] RST_TAB[9] = '{RST_ZQ, RST_RDEN, RST_RDLAT,
    RST_WREN, RST_RCTL, RST_RMRS, RST_RGAP, RST_RCMD, RST_WCTL};
  localparam logic [31:0] MSK_TAB[9] = '{MSK_ZQ, MSK_RDEN, MSK_RDLAT,
    MSK_WREN, MSK_RCTL, MSK_RMRS, MSK_RGAP, MSK_RCMD, MSK_WCTL};
  logic clk, rst, awv, wv, bry, arv, rry, awr, wr, bv, arr, rv;
  logic ren, rcs_n, rvalid, wen, wcs_n, wdat, rlvl, wlvl, resp, err;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr, exp_bank;
  logic [3:0] pat, exp_pat;
  logic [5:0] dly;
  logic [12:0] exp_mrs;
  dfi_ctl_t ctl;
  int n_mismatch, comparisons, cyc, bad_n, tr2;
  int ev_n[12], ev_cyc[12];

  dfi_train_ctrl #(.REF_INTERVAL(8)) i_dfi_train_ctrl (
    .ref_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rry), .dfi_ctl_o(ctl), .dfi_rddata_en_o(ren),
    .dfi_rddata_cs_n_o(rcs_n), .dfi_rddata_valid_i(rvalid),
    .dfi_wrdata_en_o(wen), .dfi_wrdata_cs_n_o(wcs_n), .dfi_wrdata_o(wdat),
    .dfi_rdlvl_en_o(rlvl), .dfi_wrlvl_en_o(wlvl), .dfi_lvl_pattern_o(pat),
    .dfi_lvl_resp_i(resp), .dfi_err_i(err));
  dfi_phy_model i_dfi_phy_model (.clk_i(clk), .rst_i(rst), .rd_en_i(ren),
    .lvl_en_i(rlvl | wlvl), .delay_i(dly), .valid_o(rvalid),
    .resp_o(resp));

  // ----------------------------------------
  // clock, monitor and shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic is_cmd(input dfi_cmd_t c);
    return !ctl.cs_n && ctl.cmd == c;
  endfunction : is_cmd

  task automatic note(input int i, input logic c);
    if (c === 1'b1) begin
      if (ev_n[i] == 0) ev_cyc[i] = cyc;
      ev_n[i]++;
    end
  endtask : note

  // record first cycle and count of each dfi event
  always @(posedge clk) begin
    cyc++;
    note(0, is_cmd(DCMD_READ));
    note(1, ren);
    note(2, !rcs_n);
    note(3, is_cmd(DCMD_WRITE));
    note(4, wen);
    note(5, wdat);
    note(6, !wcs_n);
    note(7, rlvl | wlvl);
    note(8, is_cmd(DCMD_REF));
    // one error pulse after the first read training command forces a replay
    err <= ev_n[9] == 0 && rlvl && is_cmd(DCMD_TRAIN);
    if (is_cmd(DCMD_TRAIN) && ev_n[9] == 1 && tr2 == 0) tr2 = cyc;
    note(9, is_cmd(DCMD_TRAIN));
    note(10, is_cmd(DCMD_MRS) && ctl.addr == exp_mrs);
    note(11, is_cmd(DCMD_ZQ));
    if ((rlvl | wlvl) && pat !== exp_pat) bad_n++;
    if (rlvl && is_cmd(DCMD_TRAIN) && ctl.bank !== exp_bank) bad_n++;
  end

  task automatic print_verdict();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    n_mismatch++;
    print_verdict();
  endtask : hang

  task automatic clear();
    bad_n = 0;
    tr2 = 0;
    for (int i = 0; i < 12; i++) ev_n[i] = 0;
  endtask : clear

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v,
                        input logic [1:0] er);
    int k;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    if (k == 50) hang();
    chk(br, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v,
                        input logic [1:0] er);
    int k;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    v = rd;
    rry <= 1'b0;
    if (k == 50) hang();
    chk(rr, er);
  endtask : axi_rd

  // poll status until the masked busy bits are clear
  task automatic wait_stat(input logic [31:0] m);
    logic [31:0] d;
    for (int k = 0; k < 300; k++) begin
      axi_rd(OFS_STAT, d, AXI_OKAY);
      if ((d & m) == 32'h0) return;
    end
    hang();
  endtask : wait_stat

  task automatic wait_ev(input int i);
    for (int k = 0; k < 300; k++) begin
      if (ev_n[i] > 0) return;
      @(posedge clk);
    end
    hang();
  endtask : wait_ev

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    {rst, awv, wv, bry, arv, rry} = 6'h20;
    err = 1'b0;
    {awa, ara, wd, dly} = {24'h0, 32'h0, 6'h03};
    {exp_pat, exp_bank, exp_mrs} = 19'h0;
    {cyc, n_mismatch, comparisons} = '0;
    clear();
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      axi_rd(OFS_TAB[i], d, AXI_OKAY);
      chk(d, RST_TAB[i]);
      axi_wr(OFS_TAB[i], 32'hFFFFFFFF, AXI_OKAY);
      axi_rd(OFS_TAB[i], d, AXI_OKAY);
      chk(d, MSK_TAB[i]);
    end
    axi_wr(12'h0F0, 32'h1, AXI_SLVERR);
    axi_rd(12'h0F0, d, AXI_SLVERR);
    // read: enable latency 5, chip-select latency 3, alignment 0x2A
    axi_wr(OFS_RDEN, 32'h00032A05, AXI_OKAY);
    axi_wr(OFS_RDLAT, 32'h8, AXI_OKAY);
    clear();
    axi_wr(OFS_CMD, 32'h1, AXI_OKAY);
    wait_ev(1);
    wait_ev(2);
    chk(ev_cyc[1] - ev_cyc[0], 5);
    chk(ev_cyc[2] - ev_cyc[0], 3);
    axi_rd(OFS_STAT, d, AXI_OKAY);
    chk(d[3], 1'b0);
    // write: latency 4, chip-select latency 2, both data delays
    for (int b = 0; b < 2; b++) begin
      axi_wr(OFS_WREN, 32'h00021504 | (b << 24), AXI_OKAY);
      clear();
      axi_wr(OFS_CMD, 32'h2, AXI_OKAY);
      wait_ev(5);
      wait_ev(6);
      chk(ev_cyc[4] - ev_cyc[3], 4);
      chk(ev_cyc[5] - ev_cyc[4], b);
      chk(ev_cyc[6] - ev_cyc[3], 2);
    end
    // zq hold of 40 drops a read issued meanwhile
    axi_wr(OFS_ZQ, 32'h00000028, AXI_OKAY);
    clear();
    axi_wr(OFS_CMD, 32'h4, AXI_OKAY);
    axi_wr(OFS_CMD, 32'h1, AXI_OKAY);
    wait_stat(32'h1);
    chk(ev_n[0], 0);
    chk((cyc - ev_cyc[11]) inside {[40:52]}, 1);
    // read training with preamble, setup, refresh first, bank 2
    {exp_pat, exp_bank, exp_mrs} = {4'hA, 2'h2, 13'h0123};
    axi_wr(OFS_RMRS, 32'h123, AXI_OKAY);
    axi_wr(OFS_RGAP, 32'h3, AXI_OKAY);
    axi_wr(OFS_RCMD, 32'h4, AXI_OKAY);
    axi_wr(OFS_RCTL, 32'h010A5410, AXI_OKAY);
    clear();
    axi_wr(OFS_CMD, 32'h8, AXI_OKAY);
    wait_stat(32'h3);
    chk(ev_n[8] > 0 && ev_cyc[8] < ev_cyc[9], 1);
    chk(bad_n, 0);
    chk(ev_n[10], 2);
    chk(tr2 - ev_cyc[9], 5);
    chk(ev_cyc[9] - ev_cyc[7] >= 3, 1);
    // write training with refresh first, refresh during and pattern 5
    exp_pat = 4'h5;
    axi_wr(OFS_WCTL, 32'h00053000, AXI_OKAY);
    clear();
    axi_wr(OFS_CMD, 32'h10, AXI_OKAY);
    wait_stat(32'h3);
    chk(ev_n[8] > 0 && ev_cyc[8] < ev_cyc[9], 1);
    chk(ev_n[8] > 1, 1);
    chk(bad_n, 0);
    // read return later than the allowed maximum of 8
    dly <= 6'h14;
    axi_wr(OFS_CMD, 32'h1, AXI_OKAY);
    for (int k = 0; k < 20 && !d[3]; k++) axi_rd(OFS_STAT, d, AXI_OKAY);
    chk(d[3], 1'b1);
    print_verdict();
  end
endmodule : dfi_train_ctrl_tb_top
